//--- core/mbw_pkg.sv
// Package: constants, state type and checksum step for the preset-multiple slave
`default_nettype none
package mbw_pkg;

  // ==========================================================================
  // Function and exception codes
  localparam logic [7:0] FN_READ_REGS   = 8'h03;
  localparam logic [7:0] FN_WRITE_ONE   = 8'h06;
  localparam logic [7:0] FN_WRITE_MULTI = 8'h10;
  localparam logic [7:0] EXC_FLAG       = 8'h80;
  localparam logic [7:0] EXC_NONE       = 8'h00;
  localparam logic [7:0] EXC_BAD_FUNC   = 8'h01;
  localparam logic [7:0] EXC_BAD_ADDR   = 8'h02;
  localparam logic [7:0] EXC_BAD_VALUE  = 8'h03;
  localparam logic [7:0] EXC_DEV_FAIL   = 8'h04;
  localparam logic [7:0] EXC_ACK_LONG   = 8'h05;
  localparam logic [7:0] EXC_DEV_BUSY   = 8'h06;
  localparam logic [7:0] EXC_PROG_NAK   = 8'h07;
  localparam logic [7:0] EXC_MEM_PARITY = 8'h08;
  localparam logic [7:0] BCAST_ADDR     = 8'h00;

  // ==========================================================================
  // Checksum
  localparam logic [15:0] CRC_INIT = 16'hFFFF;
  localparam logic [15:0] CRC_POLY = 16'hA001;
  localparam logic [15:0] CRC_GOOD = 16'h0000;

  // ==========================================================================
  // Frame layout (byte positions within a received query)
  localparam logic [5:0] POS_SLAVE    = 6'h00;
  localparam logic [5:0] POS_FUNC     = 6'h01;
  localparam logic [5:0] POS_START_HI = 6'h02;
  localparam logic [5:0] POS_START_LO = 6'h03;
  localparam logic [5:0] POS_QTY_HI   = 6'h04;
  localparam logic [5:0] POS_QTY_LO   = 6'h05;
  localparam logic [5:0] POS_BYTE_CNT = 6'h06;
  localparam logic [5:0] POS_DATA     = 6'h07;
  localparam logic [5:0] LEN_FIXED    = 6'h08;
  localparam logic [5:0] LEN_MULTI_HD = 6'h09;
  localparam logic [5:0] LEN_MIN      = 6'h04;
  localparam int         MAX_REGS     = 16;
  localparam logic [15:0] MAX_QTY     = 16'h0010;
  localparam int         FRAME_MAX    = 41;
  localparam logic [5:0] FRAME_LAST   = 6'h28;
  localparam logic [5:0] TX_LEN_EXC   = 6'h03;
  localparam logic [5:0] TX_LEN_ECHO  = 6'h06;
  localparam logic [5:0] TX_LEN_RDHDR = 6'h03;
  localparam int         GROUP_LSB    = 8;

  // ==========================================================================
  // Reply buffer
  localparam int FIFO_WIDTH = 8;
  localparam int FIFO_DEPTH = 8;

  typedef enum logic [2:0] {
    ST_RX, ST_CHECK, ST_EXEC, ST_TX, ST_CRC_LO, ST_CRC_HI
  } mbw_state_type;

  // One byte of the reflected 16-bit checksum
  function automatic logic [15:0] mbw_crc_step(input logic [15:0] crc_in,
                                               input logic [7:0]  data_in);
    logic [15:0] c;
    c = crc_in ^ {8'h00, data_in};
    for (int i = 0; i < 8; i++) begin
      c = c[0] ? ((c >> 1) ^ CRC_POLY) : (c >> 1);
    end
    return c;
  endfunction

endpackage
`default_nettype wire

//--- core/mbw_fifo.sv
// Synchronous FIFO with valid/ready on both sides
`timescale 1ns/1ps
`default_nettype none
module mbw_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8
) (
  // Clock and reset
  input  wire logic             sys_clk,
  input  wire logic             srst,
  // Fill side
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  // Drain side
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic [WIDTH-1:0]      out_data
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem_ff [DEPTH];
  logic [AW-1:0]    wr_ptr_ff;
  logic [AW-1:0]    rd_ptr_ff;
  logic [AW:0]      count_ff;
  logic             push;
  logic             pop;

  // ==========================================================================
  // Handshakes
  assign in_ready  = (count_ff != (AW+1)'(DEPTH));
  assign out_valid = (count_ff != '0);
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;
  assign out_data  = mem_ff[rd_ptr_ff];

  // Storage write
  always_ff @(posedge sys_clk) begin
    if (push) begin
      mem_ff[wr_ptr_ff] <= in_data;
    end
  end

  // Pointers and fill level
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      wr_ptr_ff <= '0;
      rd_ptr_ff <= '0;
      count_ff  <= '0;
    end else begin
      if (push) begin
        wr_ptr_ff <= (wr_ptr_ff == AW'(DEPTH-1)) ? '0 : wr_ptr_ff + 1'b1;
      end
      if (pop) begin
        rd_ptr_ff <= (rd_ptr_ff == AW'(DEPTH-1)) ? '0 : rd_ptr_ff + 1'b1;
      end
      if (push && !pop) begin
        count_ff <= count_ff + 1'b1;
      end else if (pop && !push) begin
        count_ff <= count_ff - 1'b1;
      end
    end
  end
endmodule
`default_nettype wire

//--- core/mbw_slave.sv
// Slave query interpreter: preset-multiple, preset-single, read registers, exceptions
//
// How it works
// - Register addresses are zero-based on the wire
// - Register values are two bytes, high first
// - Multi-write reply: address, function, start, count, check
// - Broadcast queries never get any reply
// - Parity or checksum error: drop query silently
// - Intact but unservable query gets exception reply
// - Normal reply echoes function code unchanged
// - Exception reply function code has top bit set
// - Exception reply: address, flagged function, code, check
// - Code 01: function not allowed
// - Code 02: address not permitted
// - Code 03: data value not acceptable
// - Code 04: unrecoverable internal failure
// - Code 05: accepted, long processing time
// - Code 06: busy, master retries later
// - Code 07: programming request refused
// - Code 08: memory parity error on read
// - One multi-write stays inside one group
// - Failed register write does not stop the rest
// - Checksum starts all ones, polynomial A001 reflected
// - Checksum low byte sent before high byte
`timescale 1ns/1ps
`default_nettype none
module mbw_slave (
  // Clock and reset
  input  wire logic        sys_clk,
  input  wire logic        srst,
  // Station setup
  input  wire logic [7:0]  slave_addr,
  input  wire logic        dev_busy,
  // Received bytes
  input  wire logic        rx_valid,
  input  wire logic [7:0]  rx_data,
  input  wire logic        rx_err,
  input  wire logic        rx_eof,
  output logic             rx_busy,
  // Register access towards the drive
  output logic             reg_req,
  output logic             reg_we,
  output logic [15:0]      reg_addr,
  output logic [15:0]      reg_wdata,
  input  wire logic        reg_ack,
  input  wire logic [15:0] reg_rdata,
  input  wire logic [7:0]  reg_status,
  // Reply bytes
  output logic             tx_valid,
  input  wire logic        tx_ready,
  output logic [7:0]       tx_data
);
  mbw_pkg::mbw_state_type state_ff;
  logic [7:0]  buf_ff [mbw_pkg::FRAME_MAX];
  logic [5:0]  rx_cnt_ff;
  logic        rx_bad_ff;
  logic [15:0] crc_rx_ff;
  logic [15:0] crc_tx_ff;
  logic [7:0]  exc_ff;
  logic        bcast_ff;
  logic [4:0]  idx_ff;
  logic [4:0]  cnt_ff;
  logic [5:0]  tx_idx_ff;
  logic [5:0]  tx_len_ff;
  logic        reg_we_ff;
  logic [15:0] reg_addr_ff;
  logic [15:0] reg_wdata_ff;

  logic [7:0]  fn;
  logic [15:0] start_addr;
  logic [15:0] qty;
  logic [16:0] end_sum;
  logic        is_read;
  logic        is_multi;
  logic        is_single;
  logic        chk_drop;
  logic [7:0]  chk_exc;
  logic [7:0]  done_exc;
  logic [4:0]  nxt_idx;
  logic [5:0]  wr_pos;
  logic [5:0]  rd_pos;
  logic        step_done;
  logic [7:0]  tx_byte;
  logic        fifo_in_valid;
  logic        fifo_in_ready;
  logic [7:0]  fifo_in_data;

  // ==========================================================================
  // Field decode of the stored query
  assign fn         = buf_ff[mbw_pkg::POS_FUNC];
  assign start_addr = {buf_ff[mbw_pkg::POS_START_HI], buf_ff[mbw_pkg::POS_START_LO]};
  assign qty        = {buf_ff[mbw_pkg::POS_QTY_HI], buf_ff[mbw_pkg::POS_QTY_LO]};
  assign end_sum    = {1'b0, start_addr} + {1'b0, qty} - 17'h00001;
  assign is_read    = (fn == mbw_pkg::FN_READ_REGS);
  assign is_multi   = (fn == mbw_pkg::FN_WRITE_MULTI);
  assign is_single  = (fn == mbw_pkg::FN_WRITE_ONE);

  // Decide whether to drop the query, and which exception it earns
  always_comb begin
    chk_drop = rx_bad_ff || (rx_cnt_ff < mbw_pkg::LEN_MIN)
               || (crc_rx_ff != mbw_pkg::CRC_GOOD);
    if ((buf_ff[mbw_pkg::POS_SLAVE] != slave_addr)
        && (buf_ff[mbw_pkg::POS_SLAVE] != mbw_pkg::BCAST_ADDR)) begin
      chk_drop = 1'b1;
    end
    if ((buf_ff[mbw_pkg::POS_SLAVE] == mbw_pkg::BCAST_ADDR) && !is_multi && !is_single) begin
      chk_drop = 1'b1;
    end
    chk_exc = mbw_pkg::EXC_NONE;
    if (!is_read && !is_multi && !is_single) begin
      chk_exc = mbw_pkg::EXC_BAD_FUNC;
    end else if (is_multi && (rx_cnt_ff != mbw_pkg::LEN_MULTI_HD
                              + buf_ff[mbw_pkg::POS_BYTE_CNT][5:0])) begin
      chk_exc = mbw_pkg::EXC_BAD_VALUE;
    end else if (!is_multi && (rx_cnt_ff != mbw_pkg::LEN_FIXED)) begin
      chk_exc = mbw_pkg::EXC_BAD_VALUE;
    end else if (!is_single && ((qty == 16'h0000) || (qty > mbw_pkg::MAX_QTY))) begin
      chk_exc = mbw_pkg::EXC_BAD_VALUE;
    end else if (is_multi && (buf_ff[mbw_pkg::POS_BYTE_CNT] != {qty[6:0], 1'b0})) begin
      chk_exc = mbw_pkg::EXC_BAD_VALUE;
    end else if (!is_single && (end_sum[16] || (end_sum[15:mbw_pkg::GROUP_LSB]
                 != start_addr[15:mbw_pkg::GROUP_LSB]))) begin
      chk_exc = mbw_pkg::EXC_BAD_ADDR;
    end else if (dev_busy) begin
      chk_exc = mbw_pkg::EXC_DEV_BUSY;
    end
  end

  // First failure of the register pass is the one reported
  assign done_exc  = (exc_ff != mbw_pkg::EXC_NONE) ? exc_ff : reg_status;
  assign step_done = (state_ff == mbw_pkg::ST_EXEC) && reg_ack;
  assign nxt_idx   = idx_ff + 5'h01;
  assign wr_pos    = mbw_pkg::POS_DATA + {nxt_idx, 1'b0};
  assign rd_pos    = mbw_pkg::POS_DATA + {idx_ff, 1'b0};

  // ==========================================================================
  // Query storage: received bytes, then read data in place of them
  always_ff @(posedge sys_clk) begin
    if ((state_ff == mbw_pkg::ST_RX) && rx_valid && !rx_eof
        && (rx_cnt_ff <= mbw_pkg::FRAME_LAST)) begin
      buf_ff[rx_cnt_ff] <= rx_data;
    end else if (step_done && !reg_we_ff) begin
      buf_ff[rd_pos]        <= reg_rdata[15:8];
      buf_ff[rd_pos + 6'h1] <= reg_rdata[7:0];
    end
  end

  // Receive count, error flag and running checksum; held over the frame end
  // so that the check state still sees them, cleared once it has run
  always_ff @(posedge sys_clk) begin
    if (srst || (state_ff != mbw_pkg::ST_RX)) begin
      rx_cnt_ff <= '0;
      rx_bad_ff <= 1'b0;
      crc_rx_ff <= mbw_pkg::CRC_INIT;
    end else if (rx_valid && !rx_eof) begin
      if (rx_cnt_ff <= mbw_pkg::FRAME_LAST) begin
        rx_cnt_ff <= rx_cnt_ff + 6'h01;
      end else begin
        rx_bad_ff <= 1'b1;
      end
      if (rx_err) begin
        rx_bad_ff <= 1'b1;
      end
      crc_rx_ff <= mbw_pkg::mbw_crc_step(crc_rx_ff, rx_data);
    end
  end

  // ==========================================================================
  // Sequencer
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      state_ff  <= mbw_pkg::ST_RX;
      exc_ff    <= mbw_pkg::EXC_NONE;
      bcast_ff  <= 1'b0;
      idx_ff    <= '0;
      cnt_ff    <= '0;
      tx_idx_ff <= '0;
      tx_len_ff <= '0;
    end else begin
      case (state_ff)
        mbw_pkg::ST_RX: begin
          if (rx_eof && (rx_cnt_ff != 6'h00)) begin
            state_ff <= mbw_pkg::ST_CHECK;
          end
        end
        mbw_pkg::ST_CHECK: begin
          bcast_ff  <= (buf_ff[mbw_pkg::POS_SLAVE] == mbw_pkg::BCAST_ADDR);
          exc_ff    <= chk_exc;
          idx_ff    <= '0;
          cnt_ff    <= is_single ? 5'h01 : qty[4:0];
          tx_idx_ff <= '0;
          tx_len_ff <= mbw_pkg::TX_LEN_EXC;
          if (chk_drop) begin
            state_ff <= mbw_pkg::ST_RX;
          end else if (chk_exc != mbw_pkg::EXC_NONE) begin
            state_ff <= (buf_ff[mbw_pkg::POS_SLAVE] == mbw_pkg::BCAST_ADDR)
                        ? mbw_pkg::ST_RX : mbw_pkg::ST_TX;
          end else begin
            state_ff <= mbw_pkg::ST_EXEC;
          end
        end
        mbw_pkg::ST_EXEC: begin
          if (reg_ack) begin
            exc_ff <= done_exc;
            idx_ff <= nxt_idx;
            if (nxt_idx == cnt_ff) begin
              state_ff <= bcast_ff ? mbw_pkg::ST_RX : mbw_pkg::ST_TX;
              if (done_exc != mbw_pkg::EXC_NONE) begin
                tx_len_ff <= mbw_pkg::TX_LEN_EXC;
              end else if (is_read) begin
                tx_len_ff <= mbw_pkg::TX_LEN_RDHDR + {cnt_ff, 1'b0};
              end else begin
                tx_len_ff <= mbw_pkg::TX_LEN_ECHO;
              end
            end
          end
        end
        mbw_pkg::ST_TX: begin
          if (fifo_in_ready) begin
            tx_idx_ff <= tx_idx_ff + 6'h01;
            if (tx_idx_ff == tx_len_ff - 6'h01) begin
              state_ff <= mbw_pkg::ST_CRC_LO;
            end
          end
        end
        mbw_pkg::ST_CRC_LO: begin
          if (fifo_in_ready) begin
            state_ff <= mbw_pkg::ST_CRC_HI;
          end
        end
        mbw_pkg::ST_CRC_HI: begin
          if (fifo_in_ready) begin
            state_ff <= mbw_pkg::ST_RX;
          end
        end
        default: begin
          state_ff <= mbw_pkg::ST_RX;
        end
      endcase
    end
  end

  // Register request address, data and direction, one register per step
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      reg_we_ff    <= 1'b0;
      reg_addr_ff  <= '0;
      reg_wdata_ff <= '0;
    end else if (state_ff == mbw_pkg::ST_CHECK) begin
      reg_we_ff    <= !is_read;
      reg_addr_ff  <= start_addr;
      reg_wdata_ff <= is_single ? qty
                      : {buf_ff[mbw_pkg::POS_DATA], buf_ff[mbw_pkg::POS_DATA + 6'h1]};
    end else if (step_done) begin
      reg_addr_ff  <= reg_addr_ff + 16'h0001;
      reg_wdata_ff <= {buf_ff[wr_pos], buf_ff[wr_pos + 6'h1]};
    end
  end

  assign reg_req   = (state_ff == mbw_pkg::ST_EXEC);
  assign reg_we    = reg_we_ff;
  assign reg_addr  = reg_addr_ff;
  assign reg_wdata = reg_wdata_ff;
  assign rx_busy   = (state_ff != mbw_pkg::ST_RX);

  // ==========================================================================
  // Reply byte selection
  always_comb begin
    if (tx_idx_ff == 6'h00) begin
      tx_byte = buf_ff[mbw_pkg::POS_SLAVE];
    end else if (tx_idx_ff == 6'h01) begin
      tx_byte = (exc_ff != mbw_pkg::EXC_NONE) ? (fn | mbw_pkg::EXC_FLAG) : fn;
    end else if (exc_ff != mbw_pkg::EXC_NONE) begin
      tx_byte = exc_ff;
    end else if (is_read && (tx_idx_ff == 6'h02)) begin
      tx_byte = {2'b00, cnt_ff, 1'b0};
    end else if (is_read) begin
      tx_byte = buf_ff[tx_idx_ff + 6'h04];
    end else begin
      tx_byte = buf_ff[tx_idx_ff];
    end
  end

  // Checksum over the reply, restarted before each reply
  always_ff @(posedge sys_clk) begin
    if (srst || (state_ff != mbw_pkg::ST_TX && state_ff != mbw_pkg::ST_CRC_LO
                 && state_ff != mbw_pkg::ST_CRC_HI)) begin
      crc_tx_ff <= mbw_pkg::CRC_INIT;
    end else if ((state_ff == mbw_pkg::ST_TX) && fifo_in_ready) begin
      crc_tx_ff <= mbw_pkg::mbw_crc_step(crc_tx_ff, tx_byte);
    end
  end

  // Feed the reply buffer; low checksum byte goes first
  always_comb begin
    fifo_in_valid = 1'b1;
    fifo_in_data  = tx_byte;
    case (state_ff)
      mbw_pkg::ST_TX:     fifo_in_data = tx_byte;
      mbw_pkg::ST_CRC_LO: fifo_in_data = crc_tx_ff[7:0];
      mbw_pkg::ST_CRC_HI: fifo_in_data = crc_tx_ff[15:8];
      default:            fifo_in_valid = 1'b0;
    endcase
  end

  // ==========================================================================
  // Reply buffer towards the line driver
  mbw_fifo #(
    .WIDTH (mbw_pkg::FIFO_WIDTH),
    .DEPTH (mbw_pkg::FIFO_DEPTH)
  ) i_mbw_fifo (
    .sys_clk   (sys_clk),
    .srst      (srst),
    .in_valid  (fifo_in_valid),
    .in_ready  (fifo_in_ready),
    .in_data   (fifo_in_data),
    .out_valid (tx_valid),
    .out_ready (tx_ready),
    .out_data  (tx_data)
  );
endmodule
`default_nettype wire

//--- testbench/mbw_slave_sva.sv
// Checker: port-level relations of the preset-multiple slave
`timescale 1ns/1ps
`default_nettype none
module mbw_slave_sva (
  // Clock and reset
  input wire logic        sys_clk,
  input wire logic        srst,
  // Station setup
  input wire logic [7:0]  slave_addr,
  input wire logic        dev_busy,
  // Received bytes
  input wire logic        rx_valid,
  input wire logic [7:0]  rx_data,
  input wire logic        rx_err,
  input wire logic        rx_eof,
  input wire logic        rx_busy,
  // Register access
  input wire logic        reg_req,
  input wire logic        reg_we,
  input wire logic [15:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic        reg_ack,
  input wire logic [15:0] reg_rdata,
  input wire logic [7:0]  reg_status,
  // Reply bytes
  input wire logic        tx_valid,
  input wire logic        tx_ready,
  input wire logic [7:0]  tx_data
);
  logic got_byte_ff;
  logic err_ff;
  logic bcast_ff;

  // ==========================================================================
  // Frame tracking: bytes held, flagged byte, broadcast address
  always_ff @(posedge sys_clk) begin
    if (srst || rx_eof) begin
      got_byte_ff <= 1'b0;
      err_ff      <= 1'b0;
      bcast_ff    <= 1'b0;
    end else if (rx_valid && !rx_busy) begin
      got_byte_ff <= 1'b1;
      err_ff      <= err_ff | rx_err;
      bcast_ff    <= got_byte_ff ? bcast_ff : (rx_data == 8'h00);
    end
  end

  // ==========================================================================
  // Properties
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (srst);

  property p_tx_hold;
    tx_valid && !tx_ready |=> tx_valid && $stable(tx_data);
  endproperty
  a_tx_hold: assert property (p_tx_hold) else $error("reply byte moved while stalled");

  property p_req_hold;
    reg_req && !reg_ack |=> reg_req && $stable(reg_addr) && $stable(reg_wdata) && $stable(reg_we);
  endproperty
  a_req_hold: assert property (p_req_hold) else $error("access changed before ack");

  property p_addr_step;
    (reg_req && reg_ack) ##1 reg_req |-> reg_addr == $past(reg_addr) + 16'h0001;
  endproperty
  a_addr_step: assert property (p_addr_step) else $error("register address not stepped");

  property p_eof_busy;
    rx_eof && !rx_busy && got_byte_ff && !err_ff |=> rx_busy;
  endproperty
  a_eof_busy: assert property (p_eof_busy) else $error("frame end not taken up");

  property p_drop_err;
    rx_eof && !rx_busy && err_ff |=> !reg_req [*4];
  endproperty
  a_drop_err: assert property (p_drop_err) else $error("flagged frame was executed");

  property p_silent;
    rx_eof && !rx_busy && (err_ff || bcast_ff) |=> (!$rose(tx_valid)) [*8];
  endproperty
  a_silent: assert property (p_silent) else $error("reply to silent frame");

  property p_tx_rise;
    $rose(tx_valid) |-> $past(rx_busy);
  endproperty
  a_tx_rise: assert property (p_tx_rise) else $error("reply without a query");

  property p_req_rise;
    $rose(reg_req) |-> rx_busy && $past(rx_busy);
  endproperty
  a_req_rise: assert property (p_req_rise) else $error("access before frame check");
endmodule
`default_nettype wire

//--- testbench/mbw_master_model.sv
// Serial master model: sends query frames and gathers reply bytes
`timescale 1ns/1ps
`default_nettype none
module mbw_master_model (
  // Clock
  input  wire logic       sys_clk,
  // Query bytes
  output logic            rx_valid,
  output logic [7:0]      rx_data,
  output logic            rx_err,
  output logic            rx_eof,
  // Reply bytes
  input  wire logic       tx_valid,
  input  wire logic [7:0] tx_data,
  output logic            tx_ready
);
  logic [7:0] got[$];
  logic       stall_en;
  logic [1:0] stall_cnt;

  // Idle line at time zero
  initial begin
    rx_valid  = 1'b0;
    rx_data   = 8'h00;
    rx_err    = 1'b0;
    rx_eof    = 1'b0;
    tx_ready  = 1'b1;
    stall_en  = 1'b0;
    stall_cnt = 2'h0;
  end

  // Checksum: preset all ones, reflected polynomial
  function automatic logic [15:0] crc16(input logic [7:0] q[$]);
    logic [15:0] c;
    c = 16'hFFFF;
    foreach (q[i]) begin
      c = c ^ {8'h00, q[i]};
      for (int b = 0; b < 8; b++) begin
        c = c[0] ? ((c >> 1) ^ 16'hA001) : (c >> 1);
      end
    end
    return c;
  endfunction

  // Sends one frame, checksum low byte first, optionally spoiled
  task automatic send(input logic [7:0] q[$], input logic bad_crc, input logic bad_par);
    logic [15:0] c;
    c = crc16(q) ^ {15'h0000, bad_crc};
    q.push_back(c[7:0]);
    q.push_back(c[15:8]);
    foreach (q[i]) begin
      @(posedge sys_clk);
      rx_valid <= 1'b1;
      rx_data  <= q[i];
      rx_err   <= bad_par && (i == 2);
    end
    @(posedge sys_clk);
    rx_valid <= 1'b0;
    rx_data  <= ~q[q.size()-1];  // Released line shows no stale byte
    rx_err   <= 1'b0;
    rx_eof   <= 1'b1;
    @(posedge sys_clk);
    rx_eof   <= 1'b0;
  endtask

  // Waits for n reply bytes; silence past the limit ends the wait
  task automatic await(input int n);
    for (int k = 0; k < 400 && got.size() < n; k++) begin
      @(posedge sys_clk);
    end
    repeat (40) @(posedge sys_clk);
  endtask

  // Takes reply bytes; stalls three cycles in four when asked
  always @(posedge sys_clk) begin
    stall_cnt <= stall_cnt + 2'h1;
    tx_ready  <= !stall_en || (stall_cnt == 2'h3);
    if (tx_valid && tx_ready) begin
      got.push_back(tx_data);
    end
  end
endmodule
`default_nettype wire

//--- testbench/mbw_slave_tb_top.sv
// Testbench top: slave with master model and drive register model
`timescale 1ns/1ps
`default_nettype none
module mbw_slave_tb_top;
  logic        sys_clk, srst, dev_busy, rx_valid, rx_err, rx_eof, rx_busy;
  logic        reg_req, reg_we, reg_ack, tx_valid, tx_ready;
  logic [7:0]  slave_addr, rx_data, reg_status, tx_data, fail_code;
  logic [15:0] reg_addr, reg_wdata, reg_rdata, fail_addr;
  logic [31:0] wr_log[$];
  int          fails, n_compared;

  mbw_slave i_mbw_slave (.sys_clk(sys_clk), .srst(srst), .slave_addr(slave_addr),
    .dev_busy(dev_busy), .rx_valid(rx_valid), .rx_data(rx_data), .rx_err(rx_err),
    .rx_eof(rx_eof), .rx_busy(rx_busy), .reg_req(reg_req), .reg_we(reg_we),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_ack(reg_ack), .reg_rdata(reg_rdata),
    .reg_status(reg_status), .tx_valid(tx_valid), .tx_ready(tx_ready), .tx_data(tx_data));
  mbw_master_model i_master (.sys_clk(sys_clk), .rx_valid(rx_valid), .rx_data(rx_data),
    .rx_err(rx_err), .rx_eof(rx_eof), .tx_valid(tx_valid), .tx_data(tx_data),
    .tx_ready(tx_ready));

  // Clock and time-zero inputs
  initial begin
    sys_clk    = 1'b0;
    srst       = 1'b1;
    slave_addr = 8'h11;
    dev_busy   = 1'b0;
    reg_ack    = 1'b0;
    reg_rdata  = 16'h0000;
    reg_status = 8'h00;
    fail_addr  = 16'hFFFF;
    fail_code  = 8'h00;
    forever #5 sys_clk = ~sys_clk;
  end

  // Drive model: acks every other cycle, reads give the inverted address
  always @(posedge sys_clk) begin
    reg_ack    <= reg_req && !reg_ack;
    reg_rdata  <= ~reg_addr;
    reg_status <= (reg_addr == fail_addr) ? fail_code : 8'h00;
    if (reg_req && reg_ack && reg_we) begin
      wr_log.push_back({reg_addr, reg_wdata});
    end
  end

  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] seen);
    n_compared++;
    if (seen !== exp) begin
      fails++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // One query, then the reply compared byte by byte
  task automatic xfer(input logic [7:0] q[$], input logic [7:0] e[$], input logic [1:0] bad);
    logic [15:0] c;
    i_master.got.delete();
    wr_log.delete();
    if (e.size() > 0) begin
      c = i_master.crc16(e);
      e.push_back(c[7:0]);
      e.push_back(c[15:8]);
    end
    i_master.send(q, bad[0], bad[1]);
    i_master.await(e.size());
    check("reply length", 32'(e.size()), 32'(i_master.got.size()));
    foreach (e[i]) check("reply byte", {24'h0, e[i]}, {24'h0, i_master.got[i]});
  endtask

  task automatic t_write_multi();
    xfer('{8'h11, 8'h10, 8'h00, 8'h01, 8'h00, 8'h02, 8'h04, 8'h00, 8'h0A, 8'h12, 8'h34},
         '{8'h11, 8'h10, 8'h00, 8'h01, 8'h00, 8'h02}, 2'b00);
    check("first write", 32'h0001000A, wr_log[0]);
    check("second write", 32'h00021234, wr_log[1]);
    $display("test write_multi done");
  endtask

  task automatic t_read();
    logic [7:0] e[$];
    e = '{8'h11, 8'h03, 8'h10};
    for (int r = 0; r < 8; r++) begin
      e.push_back(8'hFF);
      e.push_back(~(8'h10 + 8'(r)));
    end
    i_master.stall_en <= 1'b1;
    xfer('{8'h11, 8'h03, 8'h00, 8'h10, 8'h00, 8'h08}, e, 2'b00);
    i_master.stall_en <= 1'b0;
    $display("test read done");
  endtask

  task automatic t_exceptions();
    logic [7:0] q[$];
    logic [7:0] code;
    logic [7:0] drv[4] = '{8'h04, 8'h05, 8'h07, 8'h08};
    for (int k = 0; k < 8; k++) begin
      q = '{8'h11, 8'h10, 8'h00, 8'h20, 8'h00, 8'h02, 8'h04, 8'h00, 8'h01, 8'h00, 8'h02};
      fail_addr <= 16'h0020;
      fail_code <= (k > 3) ? drv[k-4] : 8'h00;
      dev_busy  <= (k == 3);
      code = (k > 3) ? drv[k-4] : 8'h06;
      case (k)
        0: begin q[1] = 8'h2B; code = 8'h01; end
        1: begin q[5] = 8'h00; code = 8'h03; end
        2: begin q[3] = 8'hFF; code = 8'h02; end
        default: ;
      endcase
      xfer(q, '{8'h11, q[1] | 8'h80, code}, 2'b00);
      check("exception flag", 32'h1, 32'(i_master.got[1][7]));
      if (k > 3) check("writes after failure", 32'h2, 32'(wr_log.size()));
    end
    dev_busy <= 1'b0;
    $display("test exceptions done");
  endtask

  task automatic t_silent();
    logic [7:0] q[$];
    logic [7:0] none[$];
    for (int k = 0; k < 4; k++) begin
      q = '{8'h11, 8'h06, 8'h00, 8'h05, 8'h12, 8'h34};
      q[0] = (k == 0) ? 8'h12 : ((k == 3) ? 8'h00 : 8'h11);
      xfer(q, none, (k == 1) ? 2'b01 : ((k == 2) ? 2'b10 : 2'b00));
      check("silent write", (k == 3) ? 32'h00051234 : 32'h0,
            (wr_log.size() > 0) ? wr_log[0] : 32'h0);
    end
    $display("test silent done");
  endtask

  task automatic complete_run();
    $display("compared %0d wrong %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  // Main sequence
  initial begin
    repeat (16) @(posedge sys_clk);
    srst <= 1'b0;
    @(posedge sys_clk);
    #1;
    check("idle outputs", 32'h0, {29'h0, rx_busy, reg_req, tx_valid});
    t_write_multi();
    t_read();
    t_exceptions();
    t_silent();
    complete_run();
  end

  // Watchdog
  initial begin
    #500000;
    fails++;
    $display("watchdog expired");
    complete_run();
  end
endmodule

bind mbw_slave mbw_slave_sva i_sva (.sys_clk(sys_clk), .srst(srst), .slave_addr(slave_addr),
  .dev_busy(dev_busy), .rx_valid(rx_valid), .rx_data(rx_data), .rx_err(rx_err),
  .rx_eof(rx_eof), .rx_busy(rx_busy), .reg_req(reg_req), .reg_we(reg_we),
  .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_ack(reg_ack), .reg_rdata(reg_rdata),
  .reg_status(reg_status), .tx_valid(tx_valid), .tx_ready(tx_ready), .tx_data(tx_data));
`default_nettype wire
